// ### logic/esr_pkg.sv
package esr_pkg;
   // system register move encoding fields
   localparam logic [1:0] ESR_OP0 = 2'h3;
   localparam logic [2:0] ESR_OP1 = 3'h6;
   localparam logic [3:0] ESR_CRN = 4'hF;
   localparam logic [3:0] ESR_CRM_PPM = 4'h2;
   localparam logic [2:0] ESR_OP2_PPM = 3'h6;
   localparam logic [3:0] ESR_CRM_AUX = 4'h4;
   localparam logic [2:0] ESR_OP2_AUX = 3'h0;
   localparam logic [3:0] ESR_CRM_ATTR = 4'h7;
   localparam logic [2:0] ESR_OP2_ATTR = 3'h0;
   localparam logic [3:0] ESR_CRM_PATCH = 4'h8;
   localparam logic [2:0] ESR_OP2_PSEL = 3'h0;
   localparam logic [2:0] ESR_OP2_PCTL = 3'h1;
   localparam logic [2:0] ESR_OP2_POPC = 3'h2;
   // exception level granting access
   localparam logic [1:0] ESR_TOP_LEVEL = 2'h3;
   // walk attribute override layout
   localparam int ESR_ATTR_VAL_LSB = 8;
   localparam int ESR_ATTR_EN_LSB = 0;
   localparam logic [63:0] ESR_ATTR_WMASK = 64'h0000_0000_0000_0F0F;
   localparam logic [63:0] ESR_ATTR_RESET = 64'h0;
   localparam logic [63:0] ESR_OPAQUE_RESET = 64'h0;
   // patch entries and selector index field
   localparam int ESR_PATCH_ENTRIES = 4;
   localparam int ESR_PATCH_IDX_W = 2;

   typedef struct packed {
      logic [1:0] op0;
      logic [2:0] op1;
      logic [3:0] crn;
      logic [3:0] crm;
      logic [2:0] op2;
   } esr_enc_t;

   typedef enum logic [5:0] {
      ESR_SEL_NONE = 6'h01,
      ESR_SEL_PPM = 6'h02,
      ESR_SEL_AUX = 6'h04,
      ESR_SEL_ATTR = 6'h08,
      ESR_SEL_PSEL = 6'h10,
      ESR_SEL_PENT = 6'h20
   } esr_sel_t;
endpackage

// ### logic/esr_reg64.sv
`timescale 1ns/10ps
module esr_reg64
   import esr_pkg::*;
#(
   parameter logic [63:0] RESET_VALUE = 64'h0,
   parameter logic [63:0] WRITE_MASK = 64'hFFFF_FFFF_FFFF_FFFF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // write side
   input wire logic wr_i,
   input wire logic [63:0] wdata_i,
   // stored value
   output logic [63:0] q_o
);
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         q_o <= RESET_VALUE;
      end else if (wr_i) begin
         q_o <= wdata_i & WRITE_MASK;
      end
   end
endmodule

// ### logic/esr_sysreg_bank.sv
`timescale 1ns/10ps
// What this block does
// - Walk value bits 11..8 drive page attribute bits 3..0 on every walk when enabled, with no level check.
// - An attribute bit whose enable (bits 3..0) is clear is driven zero on walks.
// - The walk attribute register resets to zero with bits 63..12 and 7..4 reserved zero.
// - Any access below exception level 3 is flagged undefined and changes nothing.
// - Walk attribute register sits at op0 3, op1 6, CRn 15, CRm 7, op2 0 for reads and writes.
// - Patch select, control and opcode sit at CRm 8 with op2 0, 1 and 2.
// - Power control sits at CRm 2 op2 6 and auxiliary control at CRm 4 op2 0.
// - The selector value picks which patch entry later patch accesses reach.
// - Patch control and opcode act on the entry chosen by the selector index.
// - The four opaque registers (power, auxiliary, patch control, patch opcode) are 64-bit storage with no field decoding.
module esr_sysreg_bank
   import esr_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // system register move request
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire esr_enc_t req_enc_i,
   input wire logic [1:0] req_level_i,
   input wire logic [63:0] req_wdata_i,
   // move response
   output logic resp_valid_o,
   output logic resp_undef_o,
   output logic [63:0] resp_rdata_o,
   // table walk side
   output logic [3:0] page_hw_attribute_bits_o,
   output logic [3:0] walk_attr_enable_o,
   // opaque control contents
   output logic [63:0] power_perf_control_six_o,
   output logic [63:0] aux_control_top_level_o
);
   esr_sel_t sel;
   logic hit;
   logic allowed;
   logic wr_ppm;
   logic wr_aux;
   logic wr_attr;
   logic wr_psel;
   logic wr_pctl;
   logic wr_popc;
   logic [63:0] power_perf_control_six;
   logic [63:0] aux_control_top_level;
   logic [63:0] walk_attr_override;
   logic [63:0] patch_entry_select;
   logic [63:0] patch_entry_control [ESR_PATCH_ENTRIES];
   logic [63:0] patch_entry_opcode [ESR_PATCH_ENTRIES];
   logic [ESR_PATCH_IDX_W-1:0] patch_idx;
   logic [63:0] next_rdata;

   // encoding decode
   always_comb begin
      sel = ESR_SEL_NONE;
      if (req_enc_i.op0 == ESR_OP0 && req_enc_i.op1 == ESR_OP1 && req_enc_i.crn == ESR_CRN) begin
         if (req_enc_i.crm == ESR_CRM_PPM && req_enc_i.op2 == ESR_OP2_PPM) begin
            sel = ESR_SEL_PPM;
         end else if (req_enc_i.crm == ESR_CRM_AUX && req_enc_i.op2 == ESR_OP2_AUX) begin
            sel = ESR_SEL_AUX;
         end else if (req_enc_i.crm == ESR_CRM_ATTR && req_enc_i.op2 == ESR_OP2_ATTR) begin
            sel = ESR_SEL_ATTR;
         end else if (req_enc_i.crm == ESR_CRM_PATCH) begin
            if (req_enc_i.op2 == ESR_OP2_PSEL) begin
               sel = ESR_SEL_PSEL;
            end else if (req_enc_i.op2 == ESR_OP2_PCTL || req_enc_i.op2 == ESR_OP2_POPC) begin
               sel = ESR_SEL_PENT;
            end
         end
      end
   end

   assign hit = (sel != ESR_SEL_NONE);
   // lower levels never reach storage
   assign allowed = req_valid_i && hit && (req_level_i == ESR_TOP_LEVEL);
   assign wr_ppm = allowed && req_write_i && (sel == ESR_SEL_PPM);
   assign wr_aux = allowed && req_write_i && (sel == ESR_SEL_AUX);
   assign wr_attr = allowed && req_write_i && (sel == ESR_SEL_ATTR);
   assign wr_psel = allowed && req_write_i && (sel == ESR_SEL_PSEL);
   assign wr_pctl = allowed && req_write_i && (sel == ESR_SEL_PENT)
                    && (req_enc_i.op2 == ESR_OP2_PCTL);
   assign wr_popc = allowed && req_write_i && (sel == ESR_SEL_PENT)
                    && (req_enc_i.op2 == ESR_OP2_POPC);

   // selector index in low bits
   assign patch_idx = patch_entry_select[ESR_PATCH_IDX_W-1:0];

   esr_reg64 #(
      .RESET_VALUE(ESR_OPAQUE_RESET)
   ) u_ppm (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .wr_i(wr_ppm),
      .wdata_i(req_wdata_i),
      .q_o(power_perf_control_six)
   );

   esr_reg64 #(
      .RESET_VALUE(ESR_OPAQUE_RESET)
   ) u_aux (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .wr_i(wr_aux),
      .wdata_i(req_wdata_i),
      .q_o(aux_control_top_level)
   );

   esr_reg64 #(
      .RESET_VALUE(ESR_ATTR_RESET),
      .WRITE_MASK(ESR_ATTR_WMASK)
   ) u_attr (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .wr_i(wr_attr),
      .wdata_i(req_wdata_i),
      .q_o(walk_attr_override)
   );

   esr_reg64 #(
      .RESET_VALUE(ESR_OPAQUE_RESET)
   ) u_psel (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .wr_i(wr_psel),
      .wdata_i(req_wdata_i),
      .q_o(patch_entry_select)
   );

   // patch entries addressed through the selector
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < ESR_PATCH_ENTRIES; i++) begin
            patch_entry_control[i] <= ESR_OPAQUE_RESET;
         end
      end else if (wr_pctl) begin
         patch_entry_control[patch_idx] <= req_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < ESR_PATCH_ENTRIES; i++) begin
            patch_entry_opcode[i] <= ESR_OPAQUE_RESET;
         end
      end else if (wr_popc) begin
         patch_entry_opcode[patch_idx] <= req_wdata_i;
      end
   end

   // read mux
   always_comb begin
      next_rdata = 64'h0;
      case (sel)
         ESR_SEL_PPM: next_rdata = power_perf_control_six;
         ESR_SEL_AUX: next_rdata = aux_control_top_level;
         ESR_SEL_ATTR: next_rdata = walk_attr_override & ESR_ATTR_WMASK;
         ESR_SEL_PSEL: next_rdata = patch_entry_select;
         ESR_SEL_PENT: begin
            if (req_enc_i.op2 == ESR_OP2_PCTL) begin
               next_rdata = patch_entry_control[patch_idx];
            end else begin
               next_rdata = patch_entry_opcode[patch_idx];
            end
         end
         default: next_rdata = 64'h0;
      endcase
   end

   // response, one cycle after the request
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         resp_valid_o <= 1'b0;
         resp_undef_o <= 1'b0;
         resp_rdata_o <= 64'h0;
      end else begin
         resp_valid_o <= req_valid_i;
         resp_undef_o <= req_valid_i && !allowed;
         if (allowed && !req_write_i) begin
            resp_rdata_o <= next_rdata;
         end else begin
            resp_rdata_o <= 64'h0;
         end
      end
   end

   // walk attribute outputs
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         page_hw_attribute_bits_o <= 4'h0;
         walk_attr_enable_o <= 4'h0;
      end else begin
         page_hw_attribute_bits_o <= walk_attr_override[ESR_ATTR_VAL_LSB +: 4]
                                     & walk_attr_override[ESR_ATTR_EN_LSB +: 4];
         walk_attr_enable_o <= walk_attr_override[ESR_ATTR_EN_LSB +: 4];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         power_perf_control_six_o <= 64'h0;
         aux_control_top_level_o <= 64'h0;
      end else begin
         power_perf_control_six_o <= power_perf_control_six;
         aux_control_top_level_o <= aux_control_top_level;
      end
   end
endmodule

// ### verification/esr_sysreg_bank_monitor.sv
`timescale 1ns/10ps
module esr_sysreg_bank_monitor
   import esr_pkg::*;
(
   // watched ports
   input wire logic clk_i,
   input wire logic resetn_i,
   input wire logic req_valid_i,
   input wire logic req_write_i,
   input wire esr_enc_t req_enc_i,
   input wire logic [1:0] req_level_i,
   input wire logic [63:0] req_wdata_i,
   input wire logic resp_valid_o,
   input wire logic resp_undef_o,
   input wire logic [63:0] resp_rdata_o,
   input wire logic [3:0] page_hw_attribute_bits_o,
   input wire logic [3:0] walk_attr_enable_o
);
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);
   logic top, attr;
   assign top = req_valid_i && req_level_i == 2'h3;
   assign attr = req_enc_i == {2'h3, 3'h6, 4'hF, 4'h7, 3'h0};
   property p_ans; req_valid_i |=> resp_valid_o; endproperty
   a_ans: assert property (p_ans) else $error("no answer");
   property p_idle; !req_valid_i |=> !resp_valid_o && !resp_undef_o; endproperty
   a_idle: assert property (p_idle) else $error("stray answer");
   property p_low; req_valid_i && !top |=> resp_undef_o && resp_rdata_o == 64'h0; endproperty
   a_low: assert property (p_low) else $error("low level not refused");
   property p_gate; (page_hw_attribute_bits_o & ~walk_attr_enable_o) == 4'h0; endproperty
   a_gate: assert property (p_gate) else $error("ungated attribute");
   property p_val;
      top && req_write_i && attr |-> ##2
         page_hw_attribute_bits_o == ($past(req_wdata_i[11:8], 2) & $past(req_wdata_i[3:0], 2));
   endproperty
   a_val: assert property (p_val) else $error("attribute value wrong");
   property p_en;
      top && req_write_i && attr |=> !resp_undef_o ##1 walk_attr_enable_o == $past(req_wdata_i[3:0], 2);
   endproperty
   a_en: assert property (p_en) else $error("enable wrong");
   property p_rsv;
      top && !req_write_i && attr |=> resp_rdata_o[63:12] == 52'h0 && resp_rdata_o[7:4] == 4'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_hold;
      !(req_valid_i && req_write_i) [*2] |=> $stable(walk_attr_enable_o) && $stable(page_hw_attribute_bits_o);
   endproperty
   a_hold: assert property (p_hold) else $error("attribute moved");
   property p_unm; req_valid_i && req_enc_i.crm == 4'h8 && req_enc_i.op2 > 3'h2 |=> resp_undef_o; endproperty
   a_unm: assert property (p_unm) else $error("unmapped accepted");
   c_wr: cover property (top && req_write_i && attr);
   c_rd: cover property (top && !req_write_i);
   c_low: cover property (req_valid_i && !top);
endmodule
bind esr_sysreg_bank esr_sysreg_bank_monitor u_mon (.clk_i, .resetn_i, .req_valid_i, .req_write_i,
   .req_enc_i, .req_level_i, .req_wdata_i, .resp_valid_o, .resp_undef_o, .resp_rdata_o,
   .page_hw_attribute_bits_o, .walk_attr_enable_o);

// ### verification/tb_top.sv
`timescale 1ns/10ps
module tb_top
   import esr_pkg::*;
;
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic vld = 1'b0;
   logic wr = 1'b0;
   esr_enc_t enc = '0;
   logic [1:0] lvl = 2'h3;
   logic [63:0] wd = '0;
   logic rv, ru;
   logic [63:0] rd, ppm, aux;
   logic [3:0] pba, pen;
   logic [63:0] pc [4];
   logic [63:0] po [4];
   logic [31:0] rs = 32'hA76D;
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   always #20 clk_i = ~clk_i;
   esr_sysreg_bank dut (.clk_i, .resetn_i, .req_valid_i(vld), .req_write_i(wr), .req_enc_i(enc),
      .req_level_i(lvl), .req_wdata_i(wd), .resp_valid_o(rv), .resp_undef_o(ru),
      .resp_rdata_o(rd), .page_hw_attribute_bits_o(pba), .walk_attr_enable_o(pen),
      .power_perf_control_six_o(ppm), .aux_control_top_level_o(aux));
   function automatic logic [63:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return {rs, ~rs};
   endfunction
   function automatic esr_enc_t ge(int i);
      logic [3:0] c [6] = '{4'h2, 4'h4, 4'h7, 4'h8, 4'h8, 4'h8};
      logic [2:0] o [6] = '{3'h6, 3'h0, 3'h0, 3'h0, 3'h1, 3'h2};
      return {2'h3, 3'h6, 4'hF, c[i], o[i]};
   endfunction
   function automatic logic [63:0] ev(int i, logic [63:0] w);
      return (i == 2) ? (w & 64'h0000_0000_0000_0F0F) : w;
   endfunction
   task automatic chk(input logic [63:0] g, input logic [63:0] x);
      total_checks++;
      if (g !== x) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, g, x);
      end
   endtask
   task automatic acc(input logic w, input esr_enc_t e, input logic [1:0] l,
         input logic [63:0] d, input logic xu, input logic [63:0] xd);
      @(posedge clk_i);
      vld <= 1'b1;
      wr <= w;
      enc <= e;
      lvl <= l;
      wd <= d;
      @(posedge clk_i);
      vld <= 1'b0;
      #1;
      chk(rv, 1'b1);
      chk(ru, xu);
      chk(rd, xd);
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         wrap_up();
      end
   end
   initial begin
      int i;
      logic [63:0] w, a;
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'b1;
      for (int k = 0; k < 6; k++)
         acc(1'b0, ge(k), 2'h3, '0, 1'b0, 64'h0);
      for (int k = 0; k < 30; k++) begin
         i = k % 3;
         w = (k == 5) ? '1 : rnd();
         acc(1'b1, ge(i), 2'h3, w, 1'b0, 64'h0);
         acc(1'b0, ge(i), 2'h3, w, 1'b0, ev(i, w));
         if (i == 2) a = w;
         if (i == 2) chk({pba, pen}, {w[11:8] & w[3:0], w[3:0]});
         else chk(i ? aux : ppm, w);
      end
      for (int k = 0; k < 4; k++) begin
         pc[k] = rnd();
         po[k] = rnd();
         w = (rnd() & ~64'h3) | 64'(k);
         acc(1'b1, ge(3), 2'h3, w, 1'b0, 64'h0);
         acc(1'b0, ge(3), 2'h3, '0, 1'b0, w);
         acc(1'b1, ge(4), 2'h3, pc[k], 1'b0, 64'h0);
         acc(1'b1, ge(5), 2'h3, po[k], 1'b0, 64'h0);
      end
      for (int k = 3; k >= 0; k--) begin
         acc(1'b1, ge(3), 2'h3, 64'(k), 1'b0, 64'h0);
         acc(1'b0, ge(4), 2'h3, '0, 1'b0, pc[k]);
         acc(1'b0, ge(5), 2'h3, '0, 1'b0, po[k]);
      end
      for (int l = 0; l < 3; l++) begin
         acc(1'b1, ge(2), l[1:0], '1, 1'b1, 64'h0);
         acc(1'b0, ge(l), l[1:0], '0, 1'b1, 64'h0);
      end
      acc(1'b0, ge(2), 2'h3, '0, 1'b0, ev(2, a));
      chk(pen, a[3:0]);
      acc(1'b0, {2'h3, 3'h6, 4'hF, 4'h8, 3'h3}, 2'h3, '0, 1'b1, 64'h0);
      acc(1'b0, {2'h3, 3'h4, 4'hF, 4'h7, 3'h1}, 2'h3, '0, 1'b1, 64'h0);
      wrap_up();
   end
endmodule
